// ===== rtl/csb_defines.svh
// register offsets, field positions, reset values and cycle counts
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

`define CSB_OFS_CMD 8'h00
`define CSB_OFS_OPND 8'h04
`define CSB_OFS_FLAGS 8'h08
`define CSB_OFS_STAT 8'h0c
`define CSB_OFS_PAGE 8'h10
`define CSB_OFS_RSEL 8'h14
`define CSB_OFS_RDATA 8'h18
`define CSB_OFS_SP 8'h1c

`define CSB_CMD_OP_LSB 0
`define CSB_CMD_REG_LSB 5
`define CSB_CMD_BIT_LSB 10
`define CSB_CMD_PTR_LSB 13
`define CSB_CMD_R0_BIT 15

`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5
`define CSB_FLAG_T 6
`define CSB_FLAG_I 7

`define CSB_FLAGS_RESET 8'h00
`define CSB_PAGE_RESET 8'h00
`define CSB_SP_RESET 16'h0000

`define CSB_CYC_ONE 2'h1
`define CSB_CYC_TWO 2'h2
`define CSB_CYC_THREE 2'h3

`define CSB_PTR_BASE 5'h1a

`endif

// ===== rtl/csb_pkg.sv
// types shared by the store and bit-operation execution unit
package csb_pkg;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_STORE_IND,
		OP_STORE_IND_INC,
		OP_STORE_IND_DEC,
		OP_STORE_WITH_DISPLACEMENT,
		OP_STORE_DIRECT_OP,
		OP_PROGRAM_MEMORY_LOAD,
		OP_PROGRAM_MEMORY_LOAD_INC,
		OP_EXTENDED_PROGRAM_MEMORY_LOAD,
		OP_EXTENDED_PROGRAM_MEMORY_LOAD_INC,
		OP_PUSH,
		OP_POP,
		OP_IO_BIT_SET_OP,
		OP_IO_BIT_CLEAR_OP,
		OP_LOGICAL_SHIFT_LEFT_OP,
		OP_LOGICAL_SHIFT_RIGHT_OP,
		OP_ROTATE_LEFT_CARRY_OP,
		OP_ROTATE_RIGHT_CARRY_OP,
		OP_ARITH_SHIFT_RIGHT_OP,
		OP_BIT_TO_T_OP,
		OP_T_TO_BIT_OP,
		OP_FLAG_SET,
		OP_FLAG_CLEAR,
		OP_GLOBAL_IRQ_ENABLE_OP,
		OP_GLOBAL_IRQ_DISABLE_OP,
		OP_SLEEP,
		OP_WATCHDOG_RESTART_OP,
		OP_BREAK
	} csb_op_t;

	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} csb_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} csb_dmem_req_t;

	typedef struct packed {
		logic [23:0] addr;
		logic re;
	} csb_pmem_req_t;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} csb_io_req_t;

	typedef struct packed {
		logic sleep;
		logic watchdog_restart_op;
		logic brk;
	} csb_ctl_pulse_t;

endpackage

// ===== rtl/csb_exec.sv
// store, program-load, stack, bit and flag instruction execution unit
// Operation
// - displacement store writes source to pointer plus q, pointer kept, two cycles
// - post-increment store writes at pointer, then pointer plus one, two cycles
// - pre-decrement store decrements pointer first, writes there, two cycles
// - direct store writes source to immediate address, two cycles, no flags
// - program load fetches Z byte into rd or r0, optional Z increment, three cycles
// - extended load uses page register above Z, increments both as one value
// - push writes register to stack in two cycles, flags kept
// - pop loads register from stack in two cycles, flags kept
// - io bit set forces only selected bit to one, two cycles
// - io bit clear forces only selected bit to zero, two cycles
// - logical shifts fill vacated bit with zero, update Z C N V, one cycle
// - rotate left puts old carry in bit 0, bit 7 into carry
// - rotate right puts old carry in bit 7, bit 0 into carry
// - arithmetic right shift keeps bit 7, updates Z C N V, one cycle
// - bit-to-T copies chosen register bit into T only, one cycle
// - T-to-bit copies T into chosen register bit, flags kept, one cycle
// - carry, negative, zero, sign set and clear touch only their flag
// - overflow, T, half-carry set and clear touch only their flag
// - nop, sleep and watchdog restart take one cycle, flags kept
// - break acts only with on-chip debug enabled
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "csb_defines.svh"

module csb_exec (
	// clock, reset, enable
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// data memory
	output csb_pkg::csb_dmem_req_t DMEM_REQ_OUT,
	input wire logic [7:0] DMEM_RDATA_IN,
	// program memory
	output csb_pkg::csb_pmem_req_t PMEM_REQ_OUT,
	input wire logic [7:0] PMEM_RDATA_IN,
	// io space
	output csb_pkg::csb_io_req_t IO_REQ_OUT,
	input wire logic [7:0] IO_RDATA_IN,
	// control units
	input wire logic DEBUG_EN_IN,
	output csb_pkg::csb_ctl_pulse_t CTL_PULSE_OUT
);
	import csb_pkg::*;

	csb_state_t state_reg, state_next;
	csb_op_t op_reg;
	logic [1:0] step_reg, step_next, len_reg;
	logic [4:0] rsel_cmd_reg, rsel_reg;
	logic [2:0] bit_reg;
	logic [1:0] ptr_reg;
	logic r0_reg;
	logic [15:0] opnd_reg, opnd_cmd_reg;
	logic [7:0] flags_reg, flags_next;
	logic [7:0] page_reg, page_next;
	logic [15:0] sp_reg, sp_next;
	logic [7:0] rf_reg [32], rf_next [32];

	// bus decode
	wire apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & CE_IN;
	wire idle = (state_reg == ST_IDLE);
	wire hit_cmd = (PADDR_IN == `CSB_OFS_CMD);
	wire hit_opnd = (PADDR_IN == `CSB_OFS_OPND);
	wire hit_flags = (PADDR_IN == `CSB_OFS_FLAGS);
	wire hit_stat = (PADDR_IN == `CSB_OFS_STAT);
	wire hit_page = (PADDR_IN == `CSB_OFS_PAGE);
	wire hit_rsel = (PADDR_IN == `CSB_OFS_RSEL);
	wire hit_rdata = (PADDR_IN == `CSB_OFS_RDATA);
	wire hit_sp = (PADDR_IN == `CSB_OFS_SP);
	wire hit_any = hit_cmd | hit_opnd | hit_flags | hit_stat | hit_page |
		hit_rsel | hit_rdata | hit_sp;
	wire start = apb_wr & hit_cmd & idle;
	wire sw_wr = apb_wr & idle;
	wire [4:0] cmd_op = PWDATA_IN[`CSB_CMD_OP_LSB +: 5];

	assign PREADY_OUT = CE_IN;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~hit_any;
	assign PRDATA_OUT = hit_opnd ? {16'h0000, opnd_reg} :
		hit_flags ? {24'h000000, flags_reg} :
		hit_stat ? {24'h000000, op_reg, step_reg, ~idle} :
		hit_page ? {24'h000000, page_reg} :
		hit_rsel ? {27'h0000000, rsel_reg} :
		hit_rdata ? {24'h000000, rf_reg[rsel_reg]} :
		hit_sp ? {16'h0000, sp_reg} : 32'h00000000;

	// cycles per instruction
	logic [1:0] cmd_len;
	always_comb begin
		case (cmd_op)
			OP_STORE_IND, OP_STORE_IND_INC, OP_STORE_IND_DEC,
			OP_STORE_WITH_DISPLACEMENT, OP_STORE_DIRECT_OP,
			OP_PUSH, OP_POP, OP_IO_BIT_SET_OP,
			OP_IO_BIT_CLEAR_OP: cmd_len = `CSB_CYC_TWO;
			OP_PROGRAM_MEMORY_LOAD, OP_PROGRAM_MEMORY_LOAD_INC,
			OP_EXTENDED_PROGRAM_MEMORY_LOAD,
			OP_EXTENDED_PROGRAM_MEMORY_LOAD_INC: cmd_len = `CSB_CYC_THREE;
			default: cmd_len = `CSB_CYC_ONE;
		endcase
	end

	// operands of the running instruction
	wire run = (state_reg == ST_RUN) & CE_IN;
	wire is_pload = (op_reg >= OP_PROGRAM_MEMORY_LOAD) &
		(op_reg <= OP_EXTENDED_PROGRAM_MEMORY_LOAD_INC);
	wire [1:0] ptr_sel = (is_pload || ptr_reg == 2'h3) ? 2'h2 : ptr_reg;
	wire [4:0] ptr_idx = `CSB_PTR_BASE + {2'h0, ptr_sel, 1'b0};
	wire [4:0] ptr_idx_hi = ptr_idx + 5'h01;
	wire [15:0] ptr_val = {rf_reg[ptr_idx_hi], rf_reg[ptr_idx]};
	wire [15:0] ptr_inc = ptr_val + 16'h0001;
	wire [15:0] ptr_dec = ptr_val - 16'h0001;
	wire [15:0] ptr_disp = ptr_val + {10'h000, opnd_cmd_reg[5:0]};
	wire [23:0] ext_addr = {page_reg, ptr_val};
	wire [23:0] ext_inc = ext_addr + 24'h000001;
	wire [4:0] rd_idx = r0_reg ? 5'h00 : rsel_cmd_reg;
	wire [7:0] src = rf_reg[rsel_cmd_reg];
	wire [7:0] bit_mask = 8'h01 << bit_reg;
	wire old_c = flags_reg[`CSB_FLAG_C];
	wire old_t = flags_reg[`CSB_FLAG_T];

	// shift results and carry out
	logic [7:0] sh_res;
	logic sh_c;
	always_comb begin
		case (op_reg)
			OP_LOGICAL_SHIFT_LEFT_OP: {sh_c, sh_res} = {src, 1'b0};
			OP_LOGICAL_SHIFT_RIGHT_OP: {sh_res, sh_c} = {1'b0, src};
			OP_ROTATE_LEFT_CARRY_OP: {sh_c, sh_res} = {src, old_c};
			OP_ROTATE_RIGHT_CARRY_OP: {sh_res, sh_c} = {old_c, src};
			OP_ARITH_SHIFT_RIGHT_OP: {sh_res, sh_c} = {src[7], src};
			default: {sh_c, sh_res} = 9'h000;
		endcase
	end

	// per-cycle actions
	csb_dmem_req_t dmem;
	csb_pmem_req_t pmem;
	csb_io_req_t io;
	csb_ctl_pulse_t ctl;
	logic rd_we, ptr_we;
	logic [7:0] rd_data;
	logic [15:0] ptr_new;
	wire s0 = run & (step_reg == 2'h0);
	wire s1 = run & (step_reg == 2'h1);
	always_comb begin
		dmem = '0;
		pmem = '0;
		io = '0;
		ctl = '0;
		rd_we = 1'b0;
		rd_data = 8'h00;
		ptr_we = 1'b0;
		ptr_new = ptr_val;
		flags_next = flags_reg;
		page_next = page_reg;
		sp_next = sp_reg;
		if (sw_wr && hit_flags) flags_next = PWDATA_IN[7:0];
		if (sw_wr && hit_page) page_next = PWDATA_IN[7:0];
		if (sw_wr && hit_sp) sp_next = PWDATA_IN[15:0];
		dmem.wdata = src;
		io.addr = opnd_cmd_reg[4:0];
		case (op_reg)
			OP_STORE_IND: begin
				dmem.we = s0;
				dmem.addr = ptr_val;
			end
			OP_STORE_IND_INC: begin
				dmem.we = s0;
				dmem.addr = ptr_val;
				ptr_we = s1;
				ptr_new = ptr_inc;
			end
			OP_STORE_IND_DEC: begin
				dmem.we = s0;
				dmem.addr = ptr_dec;
				ptr_we = s0;
				ptr_new = ptr_dec;
			end
			OP_STORE_WITH_DISPLACEMENT: begin
				dmem.we = s0;
				dmem.addr = ptr_disp;
			end
			OP_STORE_DIRECT_OP: begin
				dmem.we = s0;
				dmem.addr = opnd_cmd_reg;
			end
			OP_PROGRAM_MEMORY_LOAD, OP_PROGRAM_MEMORY_LOAD_INC: begin
				pmem.re = s0;
				pmem.addr = {8'h00, ptr_val};
				rd_we = s1;
				rd_data = PMEM_RDATA_IN;
				ptr_we = s1 & (op_reg == OP_PROGRAM_MEMORY_LOAD_INC);
				ptr_new = ptr_inc;
			end
			OP_EXTENDED_PROGRAM_MEMORY_LOAD,
			OP_EXTENDED_PROGRAM_MEMORY_LOAD_INC: begin
				pmem.re = s0;
				pmem.addr = ext_addr;
				rd_we = s1;
				rd_data = PMEM_RDATA_IN;
				ptr_we = s1 & (op_reg == OP_EXTENDED_PROGRAM_MEMORY_LOAD_INC);
				ptr_new = ext_inc[15:0];
				if (ptr_we) page_next = ext_inc[23:16];
			end
			OP_PUSH: begin
				dmem.we = s0;
				dmem.addr = sp_reg;
				if (s0) sp_next = sp_reg - 16'h0001;
			end
			OP_POP: begin
				dmem.re = s0;
				dmem.addr = sp_reg + 16'h0001;
				if (s0) sp_next = sp_reg + 16'h0001;
				rd_we = s1;
				rd_data = DMEM_RDATA_IN;
			end
			OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP: begin
				io.re = s0;
				io.we = s1;
				io.wdata = (op_reg == OP_IO_BIT_SET_OP) ?
					(IO_RDATA_IN | bit_mask) :
					(IO_RDATA_IN & ~bit_mask);
			end
			OP_LOGICAL_SHIFT_LEFT_OP, OP_LOGICAL_SHIFT_RIGHT_OP,
			OP_ROTATE_LEFT_CARRY_OP, OP_ROTATE_RIGHT_CARRY_OP,
			OP_ARITH_SHIFT_RIGHT_OP: begin
				rd_we = s0;
				rd_data = sh_res;
				if (s0) begin
					flags_next[`CSB_FLAG_C] = sh_c;
					flags_next[`CSB_FLAG_Z] = (sh_res == 8'h00);
					flags_next[`CSB_FLAG_N] = sh_res[7];
					flags_next[`CSB_FLAG_V] = sh_res[7] ^ sh_c;
				end
			end
			OP_BIT_TO_T_OP: begin
				if (s0) flags_next[`CSB_FLAG_T] = src[bit_reg];
			end
			OP_T_TO_BIT_OP: begin
				rd_we = s0;
				rd_data = old_t ? (src | bit_mask) : (src & ~bit_mask);
			end
			OP_FLAG_SET: begin
				if (s0) flags_next[bit_reg] = 1'b1;
			end
			OP_FLAG_CLEAR: begin
				if (s0) flags_next[bit_reg] = 1'b0;
			end
			OP_GLOBAL_IRQ_ENABLE_OP: begin
				if (s0) flags_next[`CSB_FLAG_I] = 1'b1;
			end
			OP_GLOBAL_IRQ_DISABLE_OP: begin
				if (s0) flags_next[`CSB_FLAG_I] = 1'b0;
			end
			OP_SLEEP: ctl.sleep = s0;
			OP_WATCHDOG_RESTART_OP: ctl.watchdog_restart_op = s0;
			OP_BREAK: ctl.brk = s0 & DEBUG_EN_IN;
			default: ctl = '0;
		endcase
	end

	assign DMEM_REQ_OUT = dmem;
	assign PMEM_REQ_OUT = pmem;
	assign IO_REQ_OUT = io;
	assign CTL_PULSE_OUT = ctl;

	// sequencing
	wire last = (step_reg == len_reg - 2'h1);
	always_comb begin
		state_next = state_reg;
		step_next = step_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_RUN;
					step_next = 2'h0;
				end
			end
			ST_RUN: begin
				if (last) state_next = ST_IDLE;
				else step_next = step_reg + 2'h1;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// register file update
	always_comb begin
		rf_next = rf_reg;
		if (sw_wr && hit_rdata) rf_next[rsel_reg] = PWDATA_IN[7:0];
		if (rd_we) rf_next[rd_idx] = rd_data;
		if (ptr_we) begin
			rf_next[ptr_idx] = ptr_new[7:0];
			rf_next[ptr_idx_hi] = ptr_new[15:8];
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rf_reg <= '{default: 8'h00};
		end else if (CE_IN) begin
			rf_reg <= rf_next;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg <= ST_IDLE;
			step_reg <= 2'h0;
			flags_reg <= `CSB_FLAGS_RESET;
			page_reg <= `CSB_PAGE_RESET;
			sp_reg <= `CSB_SP_RESET;
		end else if (CE_IN) begin
			state_reg <= state_next;
			step_reg <= step_next;
			flags_reg <= flags_next;
			page_reg <= page_next;
			sp_reg <= sp_next;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			opnd_reg <= 16'h0000;
			rsel_reg <= 5'h00;
		end else if (CE_IN) begin
			if (apb_wr && hit_opnd) opnd_reg <= PWDATA_IN[15:0];
			if (apb_wr && hit_rsel) rsel_reg <= PWDATA_IN[4:0];
		end
	end

	// instruction latch
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			op_reg <= OP_NOP;
			len_reg <= `CSB_CYC_ONE;
			rsel_cmd_reg <= 5'h00;
			bit_reg <= 3'h0;
			ptr_reg <= 2'h0;
			r0_reg <= 1'b0;
			opnd_cmd_reg <= 16'h0000;
		end else if (CE_IN && start) begin
			op_reg <= csb_op_t'(cmd_op);
			len_reg <= cmd_len;
			rsel_cmd_reg <= PWDATA_IN[`CSB_CMD_REG_LSB +: 5];
			bit_reg <= PWDATA_IN[`CSB_CMD_BIT_LSB +: 3];
			ptr_reg <= PWDATA_IN[`CSB_CMD_PTR_LSB +: 2];
			r0_reg <= PWDATA_IN[`CSB_CMD_R0_BIT];
			opnd_cmd_reg <= opnd_reg;
		end
	end

endmodule // csb_exec

`default_nettype wire

// ===== tb/csb_exec_chk.sv
// assertion checker for the execution unit ports
`timescale 1ns/1ns
`default_nettype none
module csb_exec_chk (
	// clock, reset, inputs
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	input wire logic DEBUG_EN_IN,
	input wire logic [7:0] IO_RDATA_IN,
	// request outputs
	input wire csb_pkg::csb_dmem_req_t DMEM_REQ_OUT,
	input wire csb_pkg::csb_pmem_req_t PMEM_REQ_OUT,
	input wire csb_pkg::csb_io_req_t IO_REQ_OUT,
	input wire csb_pkg::csb_ctl_pulse_t CTL_PULSE_OUT
);
	import csb_pkg::*;
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// io read, then write to the same place
	sequence s_io_rd;
		IO_REQ_OUT.re ##1 CE_IN;
	endsequence
	sequence s_io_wr;
		IO_REQ_OUT.we && IO_REQ_OUT.addr == $past(IO_REQ_OUT.addr);
	endsequence
	a_io_rmw: assert property (s_io_rd |-> s_io_wr)
		else $error("io write missing");
	a_io_one_bit: assert property (IO_REQ_OUT.we |->
		$countones(IO_REQ_OUT.wdata ^ IO_RDATA_IN) <= 1)
		else $error("io write alters several bits");
	a_dmem_we_once: assert property (DMEM_REQ_OUT.we |=>
		!DMEM_REQ_OUT.we)
		else $error("store wrote twice");
	a_pop_no_write: assert property (DMEM_REQ_OUT.re |->
		!DMEM_REQ_OUT.we ##1 !DMEM_REQ_OUT.we)
		else $error("pop wrote memory");
	a_pmem_gap: assert property (PMEM_REQ_OUT.re |=>
		!PMEM_REQ_OUT.re [*2])
		else $error("program fetch repeated");
	a_brk_debug: assert property (CTL_PULSE_OUT.brk |-> DEBUG_EN_IN)
		else $error("break without debug");
	a_ctl_single: assert property ((CTL_PULSE_OUT.sleep ||
		CTL_PULSE_OUT.watchdog_restart_op) |=> !(CTL_PULSE_OUT.sleep || CTL_PULSE_OUT.watchdog_restart_op))
		else $error("control pulse too long");
	a_ce_quiet: assert property (!CE_IN |-> !(DMEM_REQ_OUT.we ||
		PMEM_REQ_OUT.re || IO_REQ_OUT.we || CTL_PULSE_OUT.sleep))
		else $error("strobe while frozen");
endmodule // csb_exec_chk
bind csb_exec csb_exec_chk u_chk (.CORE_CLK_IN, .RST_N_IN, .CE_IN,
	.DEBUG_EN_IN, .IO_RDATA_IN, .DMEM_REQ_OUT, .PMEM_REQ_OUT, .IO_REQ_OUT,
	.CTL_PULSE_OUT);
`default_nettype wire

// ===== tb/csb_exec_tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/1ns
`default_nettype none
module csb_exec_tb_top;
	import csb_pkg::*;
	logic clk, rst_n, ce, psel, pen, pwr, dbg, errv, prdy, perr;
	logic [7:0] paddr, dmr, pmr, ior, wd, d, v, fv, ev, pg;
	logic [31:0] pwd, prd, rdv;
	logic [15:0] pv, k, ea, ep, z, wa;
	logic [23:0] a24, n24;
	logic [8:0] e;
	logic [7:0] dm [0:65535];
	logic [7:0] io [0:31];
	csb_dmem_req_t dq;
	csb_pmem_req_t pq;
	csb_io_req_t iq;
	csb_ctl_pulse_t cq;
	int fail_count, n_checks, op, p, r, b, c0, c1, c2, ns, nw, nb;
	csb_exec dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
		.PREADY_OUT(prdy), .PSLVERR_OUT(perr),
		.DMEM_REQ_OUT(dq), .DMEM_RDATA_IN(dmr),
		.PMEM_REQ_OUT(pq), .PMEM_RDATA_IN(pmr),
		.IO_REQ_OUT(iq), .IO_RDATA_IN(ior),
		.DEBUG_EN_IN(dbg), .CTL_PULSE_OUT(cq));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	function automatic logic [7:0] pm_f(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16];
	endfunction
	function automatic logic [8:0] shf(input int o, input logic [7:0] x,
		input logic c);
		case (o)
		14: return {x, 1'b0};
		15: return {x[0], 1'b0, x[7:1]};
		16: return {x, c};
		17: return {x[0], c, x[7:1]};
		default: return {x[0], x[7], x[7:1]};
		endcase
	endfunction
	// memory, io and pulse models
	always @(posedge clk) begin
		if (dq.we) begin
			dm[dq.addr] <= dq.wdata;
			wa <= dq.addr;
			wd <= dq.wdata;
		end
		if (dq.re) dmr <= dm[dq.addr];
		if (pq.re) pmr <= pm_f(pq.addr);
		if (iq.re) ior <= io[iq.addr];
		if (iq.we) io[iq.addr] <= iq.wdata;
		ns <= ns + int'(cq.sleep);
		nw <= nw + int'(cq.watchdog_restart_op);
		nb <= nb + int'(cq.brk);
	end
	task close_out;
		if (fail_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task bound(input logic bad);
		if (bad) begin
			fail_count++;
			close_out();
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] x);
		int i;
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwd <= x;
		ce <= ($urandom % 4 != 0);
		@(posedge clk);
		pen <= 1;
		i = 0;
		do begin
			@(posedge clk);
			ce <= 1;
			i++;
		end while (prdy !== 1'b1 && i < 20);
		rdv = prd;
		errv = perr;
		psel <= 0;
		pen <= 0;
		bound(prdy !== 1'b1);
	endtask
	task run(input int c);
		int i;
		apb(1, 8'h00, c);
		i = 0;
		do begin
			apb(0, 8'h0c, 0);
			i++;
		end while (rdv[0] !== 1'b0 && i < 20);
		bound(rdv[0] !== 1'b0);
	endtask
	task setr(input int x, input logic [7:0] y);
		apb(1, 8'h14, x);
		apb(1, 8'h18, {24'h0, y});
	endtask
	task getr(input int x);
		apb(1, 8'h14, x);
		apb(0, 8'h18, 0);
	endtask
	initial begin
		{psel, pen, pwr, dbg, paddr, pwd, dmr, pmr, ior} = '0;
		{rst_n, ce} = 2'h1;
		{fail_count, n_checks, ns, nw, nb} = '0;
		void'($urandom(32'hcc2c));
		repeat (8) @(posedge clk);
		rst_n <= 1;
		for (r = 0; r < 36; r += 4) begin
			apb(0, 8'(r), 0);
			chk(rdv, 0);
			chk(errv, r == 32);
		end
		repeat (16) begin
			op = 1 + $urandom % 5;
			p = (op == 4) ? 1 + $urandom % 3 : $urandom % 4;
			b = 26 + 2 * (p > 2 ? 2 : p);
			{pv, k, d, fv} = {$urandom, $urandom};
			r = $urandom % 26;
			setr(b, pv[7:0]);
			setr(b + 1, pv[15:8]);
			setr(r, d);
			apb(1, 8'h04, k);
			apb(1, 8'h08, fv);
			run(op | r << 5 | p << 13);
			ea = op == 5 ? k : op == 4 ? pv + k[5:0] : op == 3 ? pv - 1 : pv;
			ep = op == 2 ? pv + 1 : op == 3 ? pv - 1 : pv;
			chk(wa, ea);
			chk(wd, d);
			getr(b);
			chk(rdv, ep[7:0]);
			getr(b + 1);
			chk(rdv, ep[15:8]);
			apb(0, 8'h08, 0);
			chk(rdv, fv);
		end
		for (op = 14; op < 19; op++) begin
			for (b = 0; b < 4; b++) begin
				v = b ? 8'($urandom) : (op == 14 || op == 16 ? 8'h80 : 8'h01);
				fv = $urandom;
				r = $urandom % 32;
				setr(r, v);
				apb(1, 8'h08, fv);
				run(op | r << 5);
				e = shf(op, v, fv[0]);
				ev = {fv[7:4], e[7] ^ e[8], e[7], e[7:0] == 8'h0, e[8]};
				getr(r);
				chk(rdv, e[7:0]);
				apb(0, 8'h08, 0);
				chk(rdv, ev);
			end
		end
		for (op = 21; op < 25; op++) begin
			for (b = 0; b < 8; b++) begin
				fv = $urandom;
				ev = op > 22 ? 8'h80 : 8'h01 << b;
				ev = op % 2 ? fv | ev : fv & ~ev;
				apb(1, 8'h08, fv);
				run(op | b << 10);
				apb(0, 8'h08, 0);
				chk(rdv, ev);
			end
		end
		repeat (8) begin
			{v, fv} = $urandom;
			b = $urandom % 8;
			r = $urandom % 32;
			setr(r, v);
			apb(1, 8'h08, fv);
			run(19 | r << 5 | b << 10);
			apb(0, 8'h08, 0);
			chk(rdv, {fv[7], v[b], fv[5:0]});
			run(20 | r << 5 | (7 - b) << 10);
			getr(r);
			ev = v;
			ev[7 - b] = v[b];
			chk(rdv, ev);
		end
		for (op = 6; op < 10; op++) begin
			for (b = 0; b < 3; b++) begin
				z = b ? 16'($urandom) : 16'hffff;
				pg = $urandom;
				r = $urandom % 30;
				p = $urandom % 2;
				setr(30, z[7:0]);
				setr(31, z[15:8]);
				apb(1, 8'h10, pg);
				run(op | r << 5 | 2 << 13 | p << 15);
				a24 = {op > 7 ? pg : 8'h00, z};
				n24 = op % 2 ? a24 + 1 : a24;
				getr(p ? 0 : r);
				chk(rdv, pm_f(a24));
				getr(30);
				chk(rdv, n24[7:0]);
				getr(31);
				chk(rdv, n24[15:8]);
				apb(0, 8'h10, 0);
				chk(rdv, op > 7 ? n24[23:16] : pg);
			end
		end
		repeat (4) begin
			{pv, d, fv} = $urandom;
			r = $urandom % 32;
			apb(1, 8'h1c, pv);
			apb(1, 8'h08, fv);
			setr(r, d);
			run(10 | r << 5);
			chk(wa, pv);
			chk(wd, d);
			r = $urandom % 32;
			run(11 | r << 5);
			getr(r);
			chk(rdv, d);
			apb(0, 8'h1c, 0);
			chk(rdv, pv);
			apb(0, 8'h08, 0);
			chk(rdv, fv);
		end
		repeat (8) begin
			r = $urandom % 32;
			v = $urandom;
			io[r] = v;
			b = $urandom % 8;
			op = 12 + $urandom % 2;
			apb(1, 8'h04, r);
			run(op | b << 10);
			ev = v;
			ev[b] = op == 12;
			chk(io[r], ev);
		end
		for (op = 25; op < 34; op++) begin
			dbg <= op[0] & (op != 33);
			fv = $urandom;
			apb(1, 8'h08, fv);
			{c0, c1, c2} = {ns, nw, nb};
			run(op == 33 ? 27 : op % 32);
			chk(ns - c0, op == 25);
			chk(nw - c1, op == 26);
			chk(nb - c2, op == 27);
			apb(0, 8'h08, 0);
			chk(rdv, fv);
		end
		close_out();
	end
endmodule // csb_exec_tb_top
`default_nettype wire
